// file: design/uab_regs.svh
// constants for the autobaud and wake-on-break receiver
// assumes inclusion by bare name from design and bench files
`ifndef UAB_REGS_SVH
`define UAB_REGS_SVH
`define UAB_SYNC_CHAR 8'h55
`define UAB_EDGE_COUNT 3'h5
`define UAB_CNT_START 16'h0001
`define UAB_DIV_RESET 16'h0000
`define UAB_MEAS_DIV 4'h8
`define UAB_BASE_DIV_FAST 10'h004
`define UAB_BASE_DIV_MID 10'h010
`define UAB_BASE_DIV_SLOW 10'h040
`define UAB_MEAS_PRE_FAST 10'h020
`define UAB_MEAS_PRE_MID 10'h080
`define UAB_MEAS_PRE_SLOW 10'h200
`endif

// file: design/uab_pkg.sv
// types used by the receiver end of the autobaud link
// assumes uab_regs.svh on the include path
`default_nettype none
package uab_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT_START, ST_MEASURE} uab_abd_state_t;
	typedef enum logic [1:0] {WK_OFF, WK_WAIT_FALL, WK_WAIT_RISE} uab_wake_state_t;
endpackage
`default_nettype wire

// file: design/uab_if.sv
// serial receive line between remote node and receiver
// assumes the bench drives CLOCK_IN
`default_nettype none
interface uab_if;
	logic receive_line;
	modport device (input receive_line);
	modport remote (output receive_line);
endinterface
`default_nettype wire

// file: design/uab_device.sv
// autobaud measurement and wake-on-break receiver logic
// assumes receive_line is asynchronous to CLOCK_IN; one clock domain
`include "uab_regs.svh"
`default_nettype none
// Overview of operation
// - measure 55h sync character across five rising edges
// - enable starts calibration, receiver held idle
// - counter starts on first rise after start
// - fifth rise stores count, clears enable, flags
// - data register read clears receive flag
// - software checks high byte zero for 8-bit
// - always sixteen-bit counter during calibration
// - counter ticks at base clock over eight
// - select bits choose base and measurement clocks
// - with wake enabled, measure character after break
// - counter starts at one; software subtracts one
// - overflow flag set past sixteen bits
// - after overflow keep counting to fifth rise
// - software may clear overflow directly
// - overflow clear ignored while calibration enabled
// - wake works asynchronous mode, also in sleep
// - wake enable disables normal reception
// - wake event is falling receive line
// - flag raised at wake, async in sleep
// - data register read clears wake flag
// - rising end of break clears wake enable
// - remote sends all-zero wake character
module uab_device (
	// clock and reset
	input wire logic CLOCK_IN,
	input wire logic RST_IN,
	input wire logic CE_IN,
	// link
	uab_if.device link,
	// software controls
	input wire logic AUTOBAUD_SET_IN,
	input wire logic AUTOBAUD_CLEAR_IN,
	input wire logic WAKE_SET_IN,
	input wire logic OVF_CLEAR_IN,
	input wire logic DATA_READ_IN,
	input wire logic WIDE_DIVISOR_SELECT_IN,
	input wire logic HIGH_SPEED_SELECT_IN,
	input wire logic ASYNC_MODE_IN,
	input wire logic SLEEP_IN,
	// status
	output logic AUTOBAUD_ENABLE_OUT,
	output logic WAKE_ENABLE_OUT,
	output logic AUTOBAUD_OVERFLOW_OUT,
	output logic RX_INT_FLAG_OUT,
	output logic RX_IDLE_OUT,
	output logic [7:0] DIVISOR_HIGH_OUT,
	output logic [7:0] DIVISOR_LOW_OUT,
	output logic WAKE_ASYNC_OUT
);
	typedef struct packed {
		logic [2:0] sync;
		logic line;
		uab_pkg::uab_abd_state_t abd;
		uab_pkg::uab_wake_state_t wake;
		logic abd_en;
		logic ovf;
		logic flag;
		logic [2:0] edges;
		logic [9:0] pre;
		logic [15:0] cnt;
		logic [15:0] div;
		logic wake_async;
	} uab_state_t;
	uab_state_t s_q, s_d;

	// ****************************************
	// measurement prescaler
	// ****************************************
	function automatic logic [9:0] meas_div(input logic wide, input logic hs);
		if (wide && hs) begin
			meas_div = `UAB_MEAS_PRE_FAST;
		end else if (wide || hs) begin
			meas_div = `UAB_MEAS_PRE_MID;
		end else begin
			meas_div = `UAB_MEAS_PRE_SLOW;
		end
	endfunction

	logic rise, fall, tick;
	always_comb begin
		// second and third stage agree before a change counts
		rise = s_q.sync[2] & s_q.sync[1] & ~s_q.line;
		fall = ~s_q.sync[2] & ~s_q.sync[1] & s_q.line;
		tick = (s_q.pre == meas_div(WIDE_DIVISOR_SELECT_IN, HIGH_SPEED_SELECT_IN) - 10'h001);
	end

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		s_d = s_q;
		s_d.sync = {s_q.sync[1:0], link.receive_line};
		if (s_q.sync[2] == s_q.sync[1]) begin
			s_d.line = s_q.sync[2];
		end
		if (DATA_READ_IN) begin
			s_d.flag = 1'b0;
			s_d.wake_async = 1'b0;
		end
		if (OVF_CLEAR_IN && !s_q.abd_en) begin
			s_d.ovf = 1'b0;
		end
		if (AUTOBAUD_CLEAR_IN) begin
			s_d.abd_en = 1'b0;
			s_d.abd = uab_pkg::ST_IDLE;
		end
		if (AUTOBAUD_SET_IN && !s_q.abd_en) begin
			s_d.abd_en = 1'b1;
			s_d.abd = uab_pkg::ST_WAIT_START;
			s_d.cnt = `UAB_DIV_RESET;
		end
		// wake detector: only async mode, clockless in sleep is modelled by async flag
		case (s_q.wake)
			uab_pkg::WK_OFF: begin
				if (WAKE_SET_IN && ASYNC_MODE_IN) begin
					s_d.wake = uab_pkg::WK_WAIT_FALL;
				end
			end
			uab_pkg::WK_WAIT_FALL: begin
				if (fall) begin
					s_d.flag = 1'b1;
					s_d.wake_async = SLEEP_IN;
					s_d.wake = uab_pkg::WK_WAIT_RISE;
				end
			end
			uab_pkg::WK_WAIT_RISE: begin
				if (rise) begin
					s_d.wake = uab_pkg::WK_OFF;
				end
			end
			default: s_d.wake = uab_pkg::WK_OFF;
		endcase
		if (!ASYNC_MODE_IN) begin
			s_d.wake = uab_pkg::WK_OFF;
		end
		// measurement waits while the wake detector owns the line
		case (s_q.abd)
			uab_pkg::ST_IDLE: begin
				s_d.pre = 10'h000;
			end
			uab_pkg::ST_WAIT_START: begin
				if (rise && s_q.wake == uab_pkg::WK_OFF && !AUTOBAUD_CLEAR_IN) begin
					s_d.abd = uab_pkg::ST_MEASURE;
					s_d.cnt = `UAB_CNT_START;
					s_d.edges = 3'h1;
					s_d.pre = 10'h000;
				end
			end
			uab_pkg::ST_MEASURE: begin
				if (!AUTOBAUD_CLEAR_IN) begin
					s_d.pre = tick ? 10'h000 : s_q.pre + 10'h001;
					if (tick) begin
						s_d.cnt = s_q.cnt + 16'h0001;
						if (s_q.cnt == 16'hFFFF) begin
							s_d.ovf = 1'b1;
						end
					end
					if (rise) begin
						s_d.edges = s_q.edges + 3'h1;
						if (s_q.edges + 3'h1 == `UAB_EDGE_COUNT) begin
							// include a tick that lands on the fifth rise
							s_d.div = s_d.cnt;
							s_d.abd_en = 1'b0;
							s_d.flag = 1'b1;
							s_d.abd = uab_pkg::ST_IDLE;
						end
					end
				end
			end
			default: s_d.abd = uab_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			s_q <= '0;
			s_q.sync <= 3'h7;
			s_q.line <= 1'b1;
			s_q.abd <= uab_pkg::ST_IDLE;
			s_q.wake <= uab_pkg::WK_OFF;
		end else if (CE_IN) begin
			s_q <= s_d;
		end
	end

	// ****************************************
	// registered outputs
	// ****************************************
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			AUTOBAUD_ENABLE_OUT <= 1'b0;
			WAKE_ENABLE_OUT <= 1'b0;
			AUTOBAUD_OVERFLOW_OUT <= 1'b0;
			RX_INT_FLAG_OUT <= 1'b0;
			RX_IDLE_OUT <= 1'b1;
			DIVISOR_HIGH_OUT <= 8'h00;
			DIVISOR_LOW_OUT <= 8'h00;
			WAKE_ASYNC_OUT <= 1'b0;
		end else if (CE_IN) begin
			AUTOBAUD_ENABLE_OUT <= s_d.abd_en;
			WAKE_ENABLE_OUT <= (s_d.wake != uab_pkg::WK_OFF);
			AUTOBAUD_OVERFLOW_OUT <= s_d.ovf;
			RX_INT_FLAG_OUT <= s_d.flag;
			RX_IDLE_OUT <= 1'b1;
			DIVISOR_HIGH_OUT <= s_d.div[15:8];
			DIVISOR_LOW_OUT <= s_d.div[7:0];
			WAKE_ASYNC_OUT <= s_d.wake_async;
		end
	end
endmodule
`default_nettype wire

// file: design/uab_remote.sv
// remote node: sends a bit pattern, lsb first, with start and stop
// assumes a bit time given in CLOCK_IN cycles
`default_nettype none
module uab_remote #(
	parameter int BIT_CYCLES = 64
) (
	// clock and reset
	input wire logic CLOCK_IN,
	input wire logic RST_IN,
	input wire logic CE_IN,
	// link
	uab_if.remote link,
	// user side
	input wire logic SEND_IN,
	input wire logic [7:0] DATA_IN,
	input wire logic [3:0] STOP_BITS_IN,
	output logic BUSY_OUT
);
	typedef struct packed {
		logic busy;
		logic line;
		logic [19:0] shreg;
		logic [4:0] bits;
		logic [15:0] tmr;
	} uab_remote_state_t;
	uab_remote_state_t s_q, s_d;
	always_comb begin
		s_d = s_q;
		if (!s_q.busy) begin
			if (SEND_IN) begin
				// all-zero data with long stop gives a wake break
				s_d.busy = 1'b1;
				s_d.shreg = {11'h7FF, DATA_IN, 1'b0};
				s_d.bits = 5'h0A + {1'b0, STOP_BITS_IN};
				s_d.tmr = 16'h0000;
			end
		end else if (s_q.tmr == BIT_CYCLES[15:0] - 16'h0001) begin
			s_d.tmr = 16'h0000;
			s_d.shreg = {1'b1, s_q.shreg[19:1]};
			s_d.bits = s_q.bits - 5'h01;
			if (s_q.bits == 5'h01) begin
				s_d.busy = 1'b0;
			end
		end else begin
			s_d.tmr = s_q.tmr + 16'h0001;
		end
		s_d.line = s_d.busy ? s_d.shreg[0] : 1'b1;
	end
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			s_q <= '0;
			s_q.line <= 1'b1;
		end else if (CE_IN) begin
			s_q <= s_d;
		end
	end
	assign link.receive_line = s_q.line;
	assign BUSY_OUT = s_q.busy;
endmodule
`default_nettype wire

// file: tb/uab_assertions.sv
// checker for the autobaud and wake-on-break link
// assumes inputs driven off the clock edge; one domain
`default_nettype none
module uab_assertions (
	// clock and reset
	input wire logic CLOCK_IN,
	input wire logic RST_IN,
	// link and controls
	input wire logic receive_line,
	input wire logic AUTOBAUD_SET_IN,
	input wire logic AUTOBAUD_CLEAR_IN,
	input wire logic OVF_CLEAR_IN,
	input wire logic DATA_READ_IN,
	// status
	input wire logic AUTOBAUD_ENABLE_OUT,
	input wire logic WAKE_ENABLE_OUT,
	input wire logic AUTOBAUD_OVERFLOW_OUT,
	input wire logic RX_INT_FLAG_OUT,
	input wire logic [7:0] DIVISOR_HIGH_OUT,
	input wire logic [7:0] DIVISOR_LOW_OUT
);
	// ****
	// properties
	// ****
	default clocking @(posedge CLOCK_IN);
	endclocking
	default disable iff (RST_IN);
	a_enable_from_set: assert property ($rose(AUTOBAUD_ENABLE_OUT) |-> $past(AUTOBAUD_SET_IN))
		else $error("enable rose without set");
	a_done_sets_flag: assert property ($fell(AUTOBAUD_ENABLE_OUT) && !$past(AUTOBAUD_CLEAR_IN) |-> RX_INT_FLAG_OUT)
		else $error("completion without flag");
	a_ovf_held: assert property (AUTOBAUD_OVERFLOW_OUT && AUTOBAUD_ENABLE_OUT |=> AUTOBAUD_OVERFLOW_OUT)
		else $error("overflow dropped while enabled");
	a_ovf_cleared: assert property (OVF_CLEAR_IN && !AUTOBAUD_ENABLE_OUT |=> !AUTOBAUD_OVERFLOW_OUT)
		else $error("overflow clear ignored");
	a_read_clears: assert property (DATA_READ_IN && !AUTOBAUD_ENABLE_OUT && !WAKE_ENABLE_OUT |=> !RX_INT_FLAG_OUT)
		else $error("read left flag set");
	a_wake_fall_flag: assert property (WAKE_ENABLE_OUT && $fell(receive_line) |-> ##[1:5] RX_INT_FLAG_OUT)
		else $error("no flag at wake");
	a_wake_rise_ends: assert property (WAKE_ENABLE_OUT && $rose(receive_line) |-> ##[1:6] !WAKE_ENABLE_OUT)
		else $error("wake enable not cleared");
	a_divisor_held: assert property (!$fell(AUTOBAUD_ENABLE_OUT) |-> $stable({DIVISOR_HIGH_OUT, DIVISOR_LOW_OUT}))
		else $error("divisor moved outside completion");
	c_done: cover property ($fell(AUTOBAUD_ENABLE_OUT) && RX_INT_FLAG_OUT);
	c_wake: cover property ($fell(WAKE_ENABLE_OUT));
	c_abort: cover property ($fell(AUTOBAUD_ENABLE_OUT) && !RX_INT_FLAG_OUT);
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// bench joining receiver and remote node over the link
// assumes overflow is too long to reach; left to the checker
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	// ****
	// setup
	// ****
	localparam int BITS = 256;
	localparam logic [4:0] SET = 5'h10, CLR = 5'h08, WAKE = 5'h04, OVF = 5'h02, RD = 5'h01;
	typedef struct {logic w; logic h; int p;} uab_row_t;
	uab_row_t rows [4] = '{'{1'h1, 1'h1, 32}, '{1'h1, 1'h0, 128}, '{1'h0, 1'h1, 128}, '{1'h0, 1'h0, 512}};
	logic clk = 1'h0, rst = 1'h1, wide = 1'h1, hs = 1'h1, am = 1'h1, slp = 1'h0, snd = 1'h0, ce = 1'h1;
	logic [4:0] ctl = 5'h00;
	logic [7:0] dat = 8'h00;
	logic [3:0] stp = 4'h0;
	logic en, wen, ovf, flag, busy, idl, wasy;
	logic [7:0] dh, dl;
	int failures = 0, n_checks = 0;
	always #2 clk = ~clk;
	uab_if uab_if_i ();
	uab_device uab_device_i (.CLOCK_IN(clk), .RST_IN(rst), .CE_IN(ce), .link(uab_if_i.device),
		.AUTOBAUD_SET_IN(ctl[4]), .AUTOBAUD_CLEAR_IN(ctl[3]), .WAKE_SET_IN(ctl[2]), .OVF_CLEAR_IN(ctl[1]),
		.DATA_READ_IN(ctl[0]), .WIDE_DIVISOR_SELECT_IN(wide), .HIGH_SPEED_SELECT_IN(hs), .ASYNC_MODE_IN(am),
		.SLEEP_IN(slp), .AUTOBAUD_ENABLE_OUT(en), .WAKE_ENABLE_OUT(wen), .AUTOBAUD_OVERFLOW_OUT(ovf),
		.RX_INT_FLAG_OUT(flag), .RX_IDLE_OUT(idl), .DIVISOR_HIGH_OUT(dh), .DIVISOR_LOW_OUT(dl),
		.WAKE_ASYNC_OUT(wasy));
	uab_remote #(.BIT_CYCLES(BITS)) uab_remote_i (.CLOCK_IN(clk), .RST_IN(rst), .CE_IN(1'h1),
		.link(uab_if_i.remote), .SEND_IN(snd), .DATA_IN(dat), .STOP_BITS_IN(stp), .BUSY_OUT(busy));
	uab_assertions uab_assertions_i (.CLOCK_IN(clk), .RST_IN(rst), .receive_line(uab_if_i.receive_line),
		.AUTOBAUD_SET_IN(ctl[4]), .AUTOBAUD_CLEAR_IN(ctl[3]), .OVF_CLEAR_IN(ctl[1]), .DATA_READ_IN(ctl[0]),
		.AUTOBAUD_ENABLE_OUT(en), .WAKE_ENABLE_OUT(wen), .AUTOBAUD_OVERFLOW_OUT(ovf), .RX_INT_FLAG_OUT(flag),
		.DIVISOR_HIGH_OUT(dh), .DIVISOR_LOW_OUT(dl));
	task automatic test_done();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// tolerance of one tick: the line edge lands anywhere inside a prescale period
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g, input int t);
		n_checks++;
		if ((^g) === 1'bx || g > e + t || g + t < e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic pulse(input logic [4:0] m);
		@(posedge clk);
		ctl <= m;
		@(posedge clk);
		ctl <= 5'h00;
		#1;
	endtask
	task automatic send(input logic [7:0] d, input logic [3:0] s);
		@(posedge clk);
		snd <= 1'h1;
		dat <= d;
		stp <= s;
		@(posedge clk);
		snd <= 1'h0;
		repeat (2) @(posedge clk);
		#1;
		for (int i = 0; i < 9000 && busy !== 1'h0; i++) #4;
		#40;
	endtask
	// ****
	// tests
	// ****
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		repeat (4) @(posedge clk);
		#1;
		chk("reset", 16'h0001, {11'h000, en, wen, ovf, flag, idl}, 0);
		$display("reset test done");
		foreach (rows[r]) begin
			@(posedge clk);
			wide <= rows[r].w;
			hs <= rows[r].h;
			pulse(SET);
			chk("enable", 16'h0001, en, 0);
			send(8'h55, 4'h0);
			chk("divisor", 16'(1 + 8 * BITS / rows[r].p), {dh, dl}, 1);
			chk("high byte", 16'h0000, dh, 0);
			chk("done", 16'h0001, {en, flag}, 0);
			pulse(RD);
			chk("read", 16'h0000, flag, 0);
			$display("mode test %0d done", r);
		end
		@(posedge clk);
		am <= 1'h0;
		pulse(WAKE);
		chk("wake refused", 16'h0000, wen, 0);
		@(posedge clk);
		am <= 1'h1;
		slp <= 1'h1;
		wide <= 1'h1;
		hs <= 1'h1;
		pulse(WAKE | SET);
		chk("armed", 16'h0007, {wen, en, idl}, 0);
		send(8'h00, 4'h3);
		chk("break", 16'h0003, {wen, en, flag}, 0);
		chk("async flag", 16'h0001, wasy, 0);
		pulse(RD);
		chk("wake read", 16'h0000, {flag, wasy}, 0);
		send(8'h55, 4'h0);
		chk("after break", 16'(1 + 8 * BITS / 32), {dh, dl}, 1);
		$display("wake test done");
		pulse(RD);
		pulse(SET);
		pulse(CLR);
		pulse(OVF);
		chk("abort", 16'h0000, {en, ovf, flag}, 0);
		send(8'h55, 4'h0);
		chk("ignored char", 16'h0000, flag, 0);
		$display("abort test done");
		// reset in mid calibration, then a request at once after release
		pulse(SET);
		@(posedge clk);
		rst <= 1'h1;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		#1;
		chk("mid reset", 16'h0001, {en, wen, ovf, flag, wasy, idl}, 0);
		chk("reset divisor", 16'h0000, {dh, dl}, 0);
		pulse(SET);
		chk("set after reset", 16'h0001, en, 0);
		// clock enable low: the abort must not be taken
		@(posedge clk);
		ce <= 1'h0;
		pulse(CLR);
		chk("frozen", 16'h0001, en, 0);
		@(posedge clk);
		ce <= 1'h1;
		pulse(CLR);
		chk("resumed", 16'h0000, en, 0);
		$display("reset and enable test done");
		test_done();
	end
	initial begin
		#200000;
		failures++;
		test_done();
	end
endmodule
`default_nettype wire
